//--- hdl/hcsdp_top.sv
// Function
// - Serial clock accepted at single or double data rate, by configuration.
// - Receive data sampled on falling clock edge if edge select 0, rising if 1.
// - Transmit output is push-pull or open-drain, per open-drain select bit.
// - Transmit output high impedance when tristate control high or output enable cleared.
// - With tristate control function 0, tristate control low exactly while transmit output carries valid data.
// - Two-bit tristate control function selects tristate control timing.
// - Both tristate controls held high during reset.
// - Point-to-point mode: collision input is clear-to-send, low enables transmit.
// - Receive DMA request stays high while receive FIFO needs emptying.
// - Receive DMA moves whole blocks of 32, 16, 8 or 4 bytes.
// - Transmit DMA request stays high while transmit FIFO needs data.
// - Acknowledge with read pops receive FIFO, with write pushes transmit FIFO.
// - During acknowledge the address is ignored and the channel FIFO selected.
// - Automatic mode behaves as a normal-response-mode slave station.
`timescale 1ns/1ns
`default_nettype none

module hcsdp_top (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rd_data,
    input  wire logic       frame_sync_a,
    input  wire logic       frame_sync_b,
    input  wire logic       serial_clock_a,
    input  wire logic       serial_clock_b,
    input  wire logic       rx_serial_data_a,
    input  wire logic       rx_serial_data_b,
    input  wire logic       collision_in_a,
    input  wire logic       collision_in_b,
    input  wire logic       dma_ack_a_n,
    input  wire logic       dma_ack_b_n,
    output logic            tx_serial_data_a,
    output logic            tx_serial_data_a_oe,
    output logic            tx_serial_data_b,
    output logic            tx_serial_data_b_oe,
    output logic            tristate_ctrl_a_n,
    output logic            tristate_ctrl_b_n,
    output logic            rx_dma_request_a,
    output logic            rx_dma_request_b,
    output logic            tx_dma_request_a,
    output logic            tx_dma_request_b
);

    localparam int N = hcsdp_pkg::NUM_CH;

    hcsdp_pkg::hcsdp_pins_t pin_raw [N];
    logic [N-1:0]           ack_n;
    logic [N-1:0]           txd_q;
    logic [N-1:0]           txoe_q;
    logic [N-1:0]           tsc_n_q;
    logic [N-1:0]           rxreq_q;
    logic [N-1:0]           txreq_q;
    logic [7:0]             ch_rd_data [N];

    // Pin gathering
    assign pin_raw[0] = '{sclk: serial_clock_a, rxd: rx_serial_data_a, fsync: frame_sync_a, coll: collision_in_a};
    assign pin_raw[1] = '{sclk: serial_clock_b, rxd: rx_serial_data_b, fsync: frame_sync_b, coll: collision_in_b};
    assign ack_n      = {dma_ack_b_n, dma_ack_a_n};

    // Outputs straight from channel flops
    assign tx_serial_data_a    = txd_q[0];
    assign tx_serial_data_b    = txd_q[1];
    assign tx_serial_data_a_oe = txoe_q[0];
    assign tx_serial_data_b_oe = txoe_q[1];
    assign tristate_ctrl_a_n   = tsc_n_q[0];
    assign tristate_ctrl_b_n   = tsc_n_q[1];
    assign rx_dma_request_a    = rxreq_q[0];
    assign rx_dma_request_b    = rxreq_q[1];
    assign tx_dma_request_a    = txreq_q[0];
    assign tx_dma_request_b    = txreq_q[1];

    // Any acknowledge suspends address decoding
    wire any_ack = ~&ack_n;

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= reg_rd ? (ch_rd_data[0] | ch_rd_data[1]) : 8'h00;
        end
    end

    for (genvar c = 0; c < N; c++) begin : g_ch
        hcsdp_pkg::hcsdp_pins_t  pin_meta;
        hcsdp_pkg::hcsdp_pins_t  pin_sync;
        logic                    sclk_prev;
        logic                    fs_prev;
        logic [7:0]              cfg1;
        logic [7:0]              cfg2;
        logic [7:0]              bc_hi;
        logic [hcsdp_pkg::BC_W-1:0] tx_remaining;
        logic                    phase;
        logic                    framed;
        logic [7:0]              rx_shift;
        logic [2:0]              rx_bits;
        logic                    rx_done;
        logic [5:0]              rx_left;
        logic                    coll_flag;
        logic                    ovf_flag;
        logic                    polled;
        hcsdp_pkg::hcsdp_tx_state_t tx_state;
        logic [7:0]              tx_shift;
        logic [2:0]              tx_bits;
        logic                    rx_in_ready;
        logic                    rx_out_valid;
        logic [7:0]              rx_head;
        logic [5:0]              rx_level;
        logic                    tx_in_ready;
        logic                    tx_out_valid;
        logic [7:0]              tx_head;
        logic [5:0]              tx_level;
        hcsdp_pkg::hcsdp_cfg_t   cfg;

        // Configuration fields
        assign cfg = '{
            auto_mode:          cfg1[hcsdp_pkg::C1_AUTO],
            ddr:                cfg1[hcsdp_pkg::C1_DDR],
            clock_mode2:        cfg1[hcsdp_pkg::C1_CMODE2],
            point_to_point:     cfg1[hcsdp_pkg::C1_PTP],
            open_drain_select:  cfg1[hcsdp_pkg::C1_OPEN_DRAIN],
            blk_sel:            cfg2[hcsdp_pkg::C2_BLK_LSB +: 2],
            tristate_ctrl_func: cfg2[hcsdp_pkg::C2_TSC_LSB +: 2],
            tx_output_enable:   cfg2[hcsdp_pkg::C2_TX_OUTPUT_ENABLE],
            rx_sample_edge:     cfg2[hcsdp_pkg::C2_RX_EDGE]
        };

        // Register decode, address ignored during acknowledge
        wire       ch_hit  = ~any_ack & (reg_addr[7:4] == 4'(c));
        wire [3:0] off     = reg_addr[3:0];
        wire       wr_cfg1 = reg_wr & ch_hit & (off == hcsdp_pkg::REG_CFG1);
        wire       wr_cfg2 = reg_wr & ch_hit & (off == hcsdp_pkg::REG_CFG2);
        wire       wr_bclo = reg_wr & ch_hit & (off == hcsdp_pkg::REG_TXBC_LO);
        wire       wr_bchi = reg_wr & ch_hit & (off == hcsdp_pkg::REG_TXBC_HI);
        wire       wr_stat = reg_wr & ch_hit & (off == hcsdp_pkg::REG_STATUS);
        wire       sw_fwr  = reg_wr & ch_hit & (off == hcsdp_pkg::REG_FIFO);
        wire       sw_frd  = reg_rd & ch_hit & (off == hcsdp_pkg::REG_FIFO);

        // DMA cycles select this channel's FIFO directly
        wire dma_rd = ~ack_n[c] & reg_rd & rxreq_q[c];
        wire dma_wr = ~ack_n[c] & reg_wr & txreq_q[c];

        // Serial clock edges and bit ticks
        wire rise      = pin_sync.sclk & ~sclk_prev;
        wire fall      = ~pin_sync.sclk & sclk_prev;
        wire smp_raw   = cfg.rx_sample_edge ? rise : fall;
        wire lch_raw   = cfg.rx_sample_edge ? fall : rise;
        wire smp_tick  = smp_raw & (~cfg.ddr | phase);
        wire lch_tick  = lch_raw & (~cfg.ddr | ~phase);
        wire fs_pulse  = cfg.clock_mode2 & pin_sync.fsync & ~fs_prev;
        wire active    = cfg.clock_mode2 ? framed : pin_sync.fsync;

        // Transmit permission
        wire cts_ok    = ~cfg.point_to_point | ~pin_sync.coll;
        wire auto_ok   = ~cfg.auto_mode | polled;
        wire tx_en     = cts_ok & auto_ok & active;
        wire driving   = tx_state == hcsdp_pkg::TX_SHIFT;
        wire collide   = ~cfg.point_to_point & driving & smp_tick & tx_shift[0] & ~pin_sync.coll;
        wire tx_start  = lch_tick & tx_out_valid & tx_en;
        wire tx_last   = driving & lch_tick & (tx_bits == 3'h7);
        wire tx_pop    = (tx_state == hcsdp_pkg::TX_IDLE) ? tx_start : (tx_last & tx_start & ~collide);

        // Receive block size and request
        wire [5:0] blk_bytes = hcsdp_pkg::RX_BLK_MIN << cfg.blk_sel;
        wire       rx_pop    = dma_rd | sw_frd;

        // Tristate control and pin drive selection
        logic next_tsc_n;
        always_comb begin
            case (cfg.tristate_ctrl_func)
                hcsdp_pkg::TSC_DATA:     next_tsc_n = ~driving;
                hcsdp_pkg::TSC_ENABLED:  next_tsc_n = ~(tx_en & cfg.tx_output_enable);
                hcsdp_pkg::TSC_OFF:      next_tsc_n = 1'b1;
                hcsdp_pkg::TSC_DATA_CTS: next_tsc_n = ~(driving & cts_ok);
                default:                 next_tsc_n = 1'b1;
            endcase
        end
        wire pin_on   = ~next_tsc_n & cfg.tx_output_enable;
        wire out_bit  = driving ? tx_shift[0] : 1'b1;
        wire next_oe  = pin_on & (~cfg.open_drain_select | ~out_bit);
        wire next_txd = ~cfg.open_drain_select & out_bit;

        // Input synchronisers and edge history
        always_ff @(posedge core_clk) begin
            pin_meta  <= pin_raw[c];
            pin_sync  <= pin_meta;
            sclk_prev <= pin_sync.sclk;
            fs_prev   <= pin_sync.fsync;
        end

        // Configuration and byte count registers
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cfg1  <= hcsdp_pkg::CFG1_RST;
                cfg2  <= hcsdp_pkg::CFG2_RST;
                bc_hi <= 8'h00;
            end else begin
                if (wr_cfg1) cfg1 <= reg_wr_data;
                if (wr_cfg2) cfg2 <= reg_wr_data;
                if (wr_bchi) bc_hi <= reg_wr_data;
            end
        end

        // Remaining transmit bytes, loaded by the low byte write
        always_ff @(posedge core_clk) begin
            if (rst) begin
                tx_remaining <= '0;
            end else if (wr_bclo) begin
                tx_remaining <= {bc_hi, reg_wr_data};
            end else if (dma_wr) begin
                tx_remaining <= tx_remaining - 16'h0001;
            end
        end

        // Transmit request: bytes owed and room for one more write
        always_ff @(posedge core_clk) begin
            if (rst) begin
                txreq_q[c] <= 1'b0;
            end else begin
                txreq_q[c] <= (tx_remaining != 16'(dma_wr)) & ~wr_bclo & (tx_level < 6'(hcsdp_pkg::FIFO_DEPTH - 1));
            end
        end

        // Receive request held until a whole block has moved
        always_ff @(posedge core_clk) begin
            if (rst) begin
                rxreq_q[c] <= 1'b0;
                rx_left    <= 6'h00;
            end else if (~rxreq_q[c] & (rx_level >= blk_bytes)) begin
                rxreq_q[c] <= 1'b1;
                rx_left    <= blk_bytes;
            end else if (rxreq_q[c] & rx_pop) begin
                rx_left    <= rx_left - 6'h01;
                rxreq_q[c] <= rx_left != 6'h01;
            end
        end

        // Bit phase and frame tracking
        always_ff @(posedge core_clk) begin
            if (rst) begin
                phase  <= 1'b0;
                framed <= 1'b0;
            end else begin
                if (smp_raw) phase <= ~phase;
                if (fs_pulse) framed <= 1'b1;
                else if (~cfg.clock_mode2) framed <= 1'b0;
            end
        end

        // Receive shifter, LSB first
        always_ff @(posedge core_clk) begin
            if (rst) begin
                rx_shift <= 8'h00;
                rx_bits  <= 3'h0;
                rx_done  <= 1'b0;
            end else begin
                rx_done <= 1'b0;
                if (fs_pulse) begin
                    rx_bits <= 3'h0;
                end else if (smp_tick & active) begin
                    rx_shift <= {pin_sync.rxd, rx_shift[7:1]};
                    rx_bits  <= rx_bits + 3'h1;
                    rx_done  <= rx_bits == 3'h7;
                end
            end
        end

        // Sticky flags, set wins over clear
        always_ff @(posedge core_clk) begin
            if (rst) begin
                coll_flag <= 1'b0;
                ovf_flag  <= 1'b0;
            end else begin
                coll_flag <= collide | (coll_flag & ~(wr_stat & reg_wr_data[hcsdp_pkg::ST_COLL]));
                ovf_flag  <= (rx_done & ~rx_in_ready) | (ovf_flag & ~(wr_stat & reg_wr_data[hcsdp_pkg::ST_OVF]));
            end
        end

        // Slave station: answer only after hearing a frame
        always_ff @(posedge core_clk) begin
            if (rst) begin
                polled <= 1'b0;
            end else if (rx_done) begin
                polled <= 1'b1;
            end else if (driving & tx_last & ~tx_start) begin
                polled <= 1'b0;
            end
        end

        // Transmit state machine
        always_ff @(posedge core_clk) begin
            if (rst) begin
                tx_state <= hcsdp_pkg::TX_IDLE;
                tx_shift <= 8'hff;
                tx_bits  <= 3'h0;
            end else begin
                case (tx_state)
                    hcsdp_pkg::TX_IDLE: begin
                        if (tx_start) begin
                            tx_state <= hcsdp_pkg::TX_SHIFT;
                            tx_shift <= tx_head;
                            tx_bits  <= 3'h0;
                        end
                    end
                    hcsdp_pkg::TX_SHIFT: begin
                        if (collide) begin
                            tx_state <= hcsdp_pkg::TX_IDLE;
                        end else if (tx_last) begin
                            tx_state <= tx_start ? hcsdp_pkg::TX_SHIFT : hcsdp_pkg::TX_IDLE;
                            tx_shift <= tx_head;
                            tx_bits  <= 3'h0;
                        end else if (lch_tick) begin
                            tx_shift <= {1'b1, tx_shift[7:1]};
                            tx_bits  <= tx_bits + 3'h1;
                        end
                    end
                    default: tx_state <= hcsdp_pkg::TX_IDLE;
                endcase
            end
        end

        // Pin output flops
        always_ff @(posedge core_clk) begin
            if (rst) begin
                tsc_n_q[c] <= 1'b1;
                txoe_q[c]  <= 1'b0;
                txd_q[c]   <= 1'b1;
            end else begin
                tsc_n_q[c] <= next_tsc_n;
                txoe_q[c]  <= next_oe;
                txd_q[c]   <= next_txd;
            end
        end

        // Read value for this channel
        always_comb begin
            ch_rd_data[c] = 8'h00;
            if (dma_rd) begin
                ch_rd_data[c] = rx_head;
            end else if (ch_hit) begin
                case (off)
                    hcsdp_pkg::REG_CFG1:    ch_rd_data[c] = cfg1;
                    hcsdp_pkg::REG_CFG2:    ch_rd_data[c] = cfg2;
                    hcsdp_pkg::REG_TXBC_LO: ch_rd_data[c] = tx_remaining[7:0];
                    hcsdp_pkg::REG_TXBC_HI: ch_rd_data[c] = tx_remaining[15:8];
                    hcsdp_pkg::REG_STATUS:  ch_rd_data[c] = {3'h0, cts_ok, txreq_q[c], rxreq_q[c], ovf_flag, coll_flag};
                    hcsdp_pkg::REG_FIFO:    ch_rd_data[c] = rx_out_valid ? rx_head : 8'h00;
                    default:                ch_rd_data[c] = 8'h00;
                endcase
            end
        end

        // Receive FIFO, drained by DMA or software
        hcsdp_fifo #(.W(8), .DEPTH(hcsdp_pkg::FIFO_DEPTH), .AW(hcsdp_pkg::FIFO_AW)) u_rx_fifo (
            .clk       (core_clk),
            .rst       (rst),
            .in_valid  (rx_done),
            .in_ready  (rx_in_ready),
            .in_data   (rx_shift),
            .out_valid (rx_out_valid),
            .out_ready (rx_pop),
            .out_data  (rx_head),
            .level     (rx_level)
        );

        // Transmit FIFO, drained by the shifter which stalls when empty
        hcsdp_fifo #(.W(8), .DEPTH(hcsdp_pkg::FIFO_DEPTH), .AW(hcsdp_pkg::FIFO_AW)) u_tx_fifo (
            .clk       (core_clk),
            .rst       (rst),
            .in_valid  (dma_wr | sw_fwr),
            .in_ready  (tx_in_ready),
            .in_data   (reg_wr_data),
            .out_valid (tx_out_valid),
            .out_ready (tx_pop),
            .out_data  (tx_head),
            .level     (tx_level)
        );
    end

endmodule : hcsdp_top

`default_nettype wire

//--- hdl/hcsdp_pkg.sv
package hcsdp_pkg;

    // Sizes
    localparam int NUM_CH     = 2;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW    = 5;
    localparam int BC_W       = 16;

    // Register map: channel in addr[7:4], register in addr[3:0]
    localparam logic [3:0] REG_CFG1    = 4'h0;
    localparam logic [3:0] REG_CFG2    = 4'h1;
    localparam logic [3:0] REG_TXBC_LO = 4'h2;
    localparam logic [3:0] REG_TXBC_HI = 4'h3;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_FIFO    = 4'h5;

    // Reset values
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;

    // channel_config_1 fields
    localparam int C1_OPEN_DRAIN = 0;
    localparam int C1_PTP        = 1;
    localparam int C1_CMODE2     = 2;
    localparam int C1_DDR        = 3;
    localparam int C1_AUTO       = 4;
    // channel_config_2 fields
    localparam int C2_RX_EDGE    = 0;
    localparam int C2_TX_OUTPUT_ENABLE       = 1;
    localparam int C2_TSC_LSB    = 2;
    localparam int C2_BLK_LSB    = 4;
    // Status fields
    localparam int ST_COLL       = 0;
    localparam int ST_OVF        = 1;
    localparam int ST_RXREQ      = 2;
    localparam int ST_TXREQ      = 3;
    localparam int ST_CTS        = 4;

    // Smallest receive block, shifted left by the block select
    localparam logic [5:0] RX_BLK_MIN = 6'h04;

    // Tristate control functions
    localparam logic [1:0] TSC_DATA     = 2'h0;
    localparam logic [1:0] TSC_ENABLED  = 2'h1;
    localparam logic [1:0] TSC_OFF      = 2'h2;
    localparam logic [1:0] TSC_DATA_CTS = 2'h3;

    typedef struct packed {
        logic       auto_mode;
        logic       ddr;
        logic       clock_mode2;
        logic       point_to_point;
        logic       open_drain_select;
        logic [1:0] blk_sel;
        logic [1:0] tristate_ctrl_func;
        logic       tx_output_enable;
        logic       rx_sample_edge;
    } hcsdp_cfg_t;

    typedef struct packed {
        logic sclk;
        logic rxd;
        logic fsync;
        logic coll;
    } hcsdp_pins_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } hcsdp_tx_state_t;

endpackage : hcsdp_pkg

//--- hdl/hcsdp_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module hcsdp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [AW:0]        level
);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;

    // Handshakes and pointers
    wire          push        = in_valid & in_ready;
    wire          pop         = out_valid & out_ready;
    wire [AW:0]   next_rd_ptr = rd_ptr + (AW+1)'(pop);
    wire          bypass      = push & (wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]);

    assign level     = wr_ptr - rd_ptr;
    assign in_ready  = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;

    // Pointer update
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage and registered head word
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
        out_data <= bypass ? in_data : mem[next_rd_ptr[AW-1:0]];
    end

endmodule : hcsdp_fifo

`default_nettype wire

//--- test/hcsdp_chk.sv
`timescale 1ns/1ns
`default_nettype none

module hcsdp_chk (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rd_data,
    input wire logic       dma_ack_a_n,
    input wire logic       tx_serial_data_a_oe,
    input wire logic       tx_serial_data_b_oe,
    input wire logic       tristate_ctrl_a_n,
    input wire logic       tristate_ctrl_b_n,
    input wire logic       rx_dma_request_a,
    input wire logic       tx_dma_request_a
);
    logic [5:0] pop_a;
    logic       pop_hit;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Pops taken within one receive request
    assign pop_hit = reg_rd && (!dma_ack_a_n || reg_addr == 8'h05);
    always_ff @(posedge core_clk) begin
        pop_a <= rx_dma_request_a ? pop_a + 6'(pop_hit) : 6'h00;
    end

    a_tsc_in_reset: assert property (disable iff (1'b0) rst |=> tristate_ctrl_a_n && tristate_ctrl_b_n)
        else $error("tristate control low in reset");
    a_tsc_after_reset: assert property ($fell(rst) |-> tristate_ctrl_a_n && !tx_serial_data_a_oe)
        else $error("channel a driving right after reset");
    a_oe_needs_tsc_a: assert property (tx_serial_data_a_oe |-> !tristate_ctrl_a_n)
        else $error("channel a driven with tristate control high");
    a_oe_needs_tsc_b: assert property (tx_serial_data_b_oe |-> !tristate_ctrl_b_n)
        else $error("channel b driven with tristate control high");
    a_rx_fall_on_pop: assert property ($fell(rx_dma_request_a) && !$past(rst) |-> $past(reg_rd))
        else $error("receive request dropped without a pop");
    a_rx_block_len: assert property ($fell(rx_dma_request_a) && !$past(rst) |-> pop_a inside {4, 8, 16, 32})
        else $error("receive request dropped after a partial block");
    a_tx_fall_on_wr: assert property ($fell(tx_dma_request_a) && !$past(rst) |-> $past(reg_wr, 1) || $past(reg_wr, 2))
        else $error("transmit request dropped without a write");
    a_rd_data_idle: assert property (!$past(reg_rd) |-> reg_rd_data == 8'h00)
        else $error("read data outside the answer cycle");
endmodule : hcsdp_chk

bind hcsdp_top hcsdp_chk u_chk (.core_clk, .rst, .reg_addr, .reg_rd, .reg_wr, .reg_rd_data, .dma_ack_a_n,
    .tx_serial_data_a_oe, .tx_serial_data_b_oe, .tristate_ctrl_a_n, .tristate_ctrl_b_n, .rx_dma_request_a,
    .tx_dma_request_a);

`default_nettype wire

//--- test/hcsdp_line.sv
`timescale 1ns/1ns
`default_nettype none

module hcsdp_line (
    output logic sclk,
    output logic sdata,
    output logic fsync
);
    // Line idle: clock parked, strobe low
    initial begin
        sclk  = 1'b0;
        sdata = 1'b1;
        fsync = 1'b0;
    end

    // One byte LSB first, bit valid only around the sampling edge
    task automatic send_byte(input logic [7:0] b, input logic rise);
        fsync = 1'b1;
        #80;
        for (int i = 0; i < 8; i++) begin
            sclk = ~rise;
            #40 sdata = b[i];
            #40 sclk = rise;
            #40 sdata = ~b[i];
            #40;
        end
        sclk = 1'b0;
        #80 fsync = 1'b0;
        #160;
    endtask : send_byte
endmodule : hcsdp_line

`default_nettype wire

//--- test/hcsdp_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

module hcsdp_top_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       dma_ack_a_n = 1'b1;
    logic       collision_in_a = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] reg_rd_data;
    logic       frame_sync_a, serial_clock_a, rx_serial_data_a, tx_serial_data_a, tx_serial_data_a_oe;
    logic       tristate_ctrl_a_n, tristate_ctrl_b_n, rx_dma_request_a, tx_dma_request_a;
    int         errors = 0;
    int         check_count = 0;
    int         cyc = 0;

    hcsdp_line line (.sclk(serial_clock_a), .sdata(rx_serial_data_a), .fsync(frame_sync_a));
    hcsdp_top dut (.core_clk, .rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .frame_sync_a,
        .frame_sync_b(1'b0), .serial_clock_a, .serial_clock_b(1'b0), .rx_serial_data_a, .rx_serial_data_b(1'b1),
        .collision_in_a, .collision_in_b(1'b0), .dma_ack_a_n, .dma_ack_b_n(1'b1), .tx_serial_data_a,
        .tx_serial_data_a_oe, .tx_serial_data_b(), .tx_serial_data_b_oe(), .tristate_ctrl_a_n, .tristate_ctrl_b_n,
        .rx_dma_request_a, .rx_dma_request_b(), .tx_dma_request_a, .tx_dma_request_b());

    // Clock and hang guard
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr      <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rd_data & m, exp);
    endtask : rd

    task automatic t_reset();
        chk(8'({tristate_ctrl_a_n, tristate_ctrl_b_n, tx_serial_data_a_oe}), 8'h06);
        rd(8'h01, 8'hff, 8'h00);
        rd(8'h29, 8'hff, 8'h00);
    endtask : t_reset

    task automatic t_tsc();
        logic [7:0] cfg [4] = '{8'h06, 8'h0a, 8'h04, 8'h02};
        logic [1:0] exp [4] = '{2'b01, 2'b10, 2'b10, 2'b10};
        line.fsync <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, cfg[i]);
            repeat (2) @(posedge core_clk);
            chk(8'({tristate_ctrl_a_n, tx_serial_data_a_oe}), 8'(exp[i]));
        end
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h06);
        repeat (2) @(posedge core_clk);
        chk(8'({tristate_ctrl_a_n, tx_serial_data_a_oe, tx_serial_data_a}), 8'h00);
        wr(8'h00, 8'h02);
        collision_in_a <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h04, 8'h10, 8'h00);
        @(posedge core_clk);
        collision_in_a <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(8'h04, 8'h10, 8'h10);
        wr(8'h00, 8'h00);
        line.fsync <= 1'b0;
    endtask : t_tsc

    task automatic t_rx(input logic rise);
        logic [7:0] d [4] = '{8'h01, 8'h80, 8'hc5, 8'h3a};
        wr(8'h01, 8'(rise));
        for (int i = 0; i < 4; i++) line.send_byte(d[i], rise);
        for (int n = 0; n < 40 && rx_dma_request_a !== 1'b1; n++) @(posedge core_clk);
        chk(8'(rx_dma_request_a), 8'h01);
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            reg_addr    <= 8'h14;
            reg_rd      <= (i < 4);
            dma_ack_a_n <= (i >= 4);
            #1 if (i > 0) chk(reg_rd_data, (i < 5) ? d[(i-1)%4] : 8'h00);
            if (i == 3) chk(8'(rx_dma_request_a), 8'h01);
        end
        chk(8'(rx_dma_request_a), 8'h00);
    endtask : t_rx

    task automatic t_tx();
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h02);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            reg_addr    <= 8'h31;
            reg_wr      <= (i < 2);
            dma_ack_a_n <= (i >= 2);
            reg_wr_data <= 8'h70 + 8'(i);
            #1 if (i == 1) chk(8'(tx_dma_request_a), 8'h01);
            if (i == 3) chk(8'(tx_dma_request_a), 8'h00);
        end
        rd(8'h02, 8'hff, 8'h00);
    endtask : t_tx

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_tsc();
        t_rx(1'b0);
        t_rx(1'b1);
        t_tx();
        give_verdict();
    end
endmodule : hcsdp_top_tb

`default_nettype wire
